//--- rtl/lpr_regs.svh
/*
  Frame layout, field positions, reset values and host register map
  for the LIN transceiver and start-up parameter registers.
  Assumes inclusion by bare name; definitions only.
*/
`ifndef LPR_REGS_SVH
`define LPR_REGS_SVH
// ---------------------------------------------------------------
// frame fields
// ---------------------------------------------------------------
`define LPR_FRAME_BITS 5'h10
`define LPR_SEL_HI 15
`define LPR_SEL_LO 14
`define LPR_RRS_BIT 13
`define LPR_NOWR_BIT 12
`define LPR_SEL_CFG 2'h3
`define LPR_SEL_STUP 2'h1
// ---------------------------------------------------------------
// transceiver_config fields
// ---------------------------------------------------------------
`define LPR_CFG_ACT_BIT 4
`define LPR_CFG_EDGE_BIT 3
`define LPR_CFG_DRV_BIT 2
`define LPR_CFG_TXD_BIT 0
// ---------------------------------------------------------------
// startup_params fields
// ---------------------------------------------------------------
`define LPR_SU_SDM_BIT 9
`define LPR_SU_WDP_HI 6
`define LPR_SU_WDP_LO 5
`define LPR_SU_THR_HI 4
`define LPR_SU_THR_LO 3
// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define LPR_RST_CFG 5'h00
`define LPR_RST_SDM 1'h0
`define LPR_RST_WDP 2'h0
`define LPR_RST_THR 2'h0
// ---------------------------------------------------------------
// decoded scale (x2) and threshold (percent)
// ---------------------------------------------------------------
`define LPR_WDX2_00 3'h2
`define LPR_WDX2_01 3'h3
`define LPR_WDX2_10 3'h5
`define LPR_WDX2_11 3'h7
`define LPR_THR_PCT_HI 7'h5A
`define LPR_THR_PCT_10 7'h46
`define LPR_THR_PCT_01 7'h50
// ---------------------------------------------------------------
// host apb map and link timing
// ---------------------------------------------------------------
`define LPR_HOST_CMD 8'h00
`define LPR_HOST_STAT 8'h04
`define LPR_HOST_RXD 8'h08
`define LPR_HALF_CYC 8'h04
`endif

//--- rtl/lpr_pkg.sv
/*
  Types for both ends of the link, and decode functions used by the device end only.
  Assumes lpr_regs.svh on the include path.
*/
`include "lpr_regs.svh"
package lpr_pkg;
  typedef enum logic [1:0] {
    LPR_IDLE = 2'h0,
    LPR_LEAD = 2'h1,
    LPR_SHIFT = 2'h3,
    LPR_TAIL = 2'h2
  } lpr_state_e;

  typedef struct packed {
    logic sclk_s1, sclk_s2, sclk_d;
    logic csn_s1, csn_s2, csn_d;
    logic mosi_s1, mosi_s2;
    logic [15:0] rx;
    logic [4:0] cnt;
    logic [15:0] tx;
    logic miso;
    logic act_en, edge_sel, drv_sel, tx_dis;
    logic fail;
    logic sdm;
    logic [1:0] wdp;
    logic [1:0] thr;
    logic bus_active, tx_en;
    logic [2:0] wd_x2;
    logic [6:0] thr_pct;
    logic edge_wake_status, wake_level_status;
  } lpr_dev_s;

  typedef struct packed {
    lpr_state_e st;
    logic [7:0] cnt;
    logic [3:0] bits;
    logic sclk, csn, mosi;
    logic miso_s1, miso_s2;
    logic [15:0] txw;
    logic [15:0] sh;
    logic [15:0] rxw;
    logic done;
    logic wr_ok;
    logic pready, pslverr;
    logic [31:0] prdata;
  } lpr_host_s;

  function automatic logic [2:0] lpr_wd_x2(input logic [1:0] c);
    case (c)
      2'h0: lpr_wd_x2 = `LPR_WDX2_00;
      2'h1: lpr_wd_x2 = `LPR_WDX2_01;
      2'h2: lpr_wd_x2 = `LPR_WDX2_10;
      default: lpr_wd_x2 = `LPR_WDX2_11;
    endcase
  endfunction

  function automatic logic [6:0] lpr_thr_pct(input logic [1:0] c);
    case (c)
      2'h2: lpr_thr_pct = `LPR_THR_PCT_10;
      2'h1: lpr_thr_pct = `LPR_THR_PCT_01;
      default: lpr_thr_pct = `LPR_THR_PCT_HI;
    endcase
  endfunction
endpackage

//--- rtl/lpr_if.sv
/*
  Four-wire serial link between controller and device.
  Assumes the bench supplies nothing beyond these wires.
*/
interface lpr_if;
  logic sclk;
  logic csn;
  logic mosi;
  logic miso;
  modport dev (input sclk, input csn, input mosi, output miso);
  modport host (output sclk, output csn, output mosi, input miso);
endinterface

//--- rtl/lpr_dev.sv
/*
  Device end: transceiver configuration and start-up parameter
  registers behind a 16-bit serial frame, msb first.
  Assumes the link pins are asynchronous to i_clk and that the
  half period of sclk spans at least four i_clk cycles.
*/
// Decided for this implementation: the APB interface to the registers and the register offsets.
`include "lpr_regs.svh"
module lpr_dev (
  input wire logic i_clk,
  input wire logic i_rst_n,
  lpr_if.dev link,
  input wire logic i_mode_active,
  input wire logic i_if_fail,
  input wire logic i_traffic_ok,
  input wire logic [11:0] i_gp1_feedback,
  input wire logic [11:0] i_int_en_feedback,
  input wire logic i_wake_enable,
  input wire logic i_wake_edge,
  input wire logic i_wake_level,
  input wire logic i_wake_status_clr,
  output logic o_bus_active,
  output logic o_edge_rate_sel,
  output logic o_drive_strength_sel,
  output logic o_transmitter_disable,
  output logic o_tx_enable,
  output logic o_sw_dev_mode_init,
  output logic [1:0] o_watchdog_prescale,
  output logic [1:0] o_supply_reset_threshold,
  output logic [2:0] o_wd_scale_x2,
  output logic [6:0] o_reset_thresh_pct,
  output logic o_edge_wake_status,
  output logic o_wake_level_status
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  lpr_pkg::lpr_dev_s state_ff;
  lpr_pkg::lpr_dev_s nxt_state;

  logic csn_fall;
  logic csn_rise;
  logic sclk_rise;
  logic sclk_fall;
  logic in_frame;
  logic full_frame;
  logic [1:0] sel;
  logic readback_select;
  logic no_wr;

  assign csn_fall = !state_ff.csn_s2 && state_ff.csn_d;
  assign csn_rise = state_ff.csn_s2 && !state_ff.csn_d;
  assign sclk_rise = state_ff.sclk_s2 && !state_ff.sclk_d;
  assign sclk_fall = !state_ff.sclk_s2 && state_ff.sclk_d;
  assign in_frame = !state_ff.csn_s2;
  assign full_frame = state_ff.cnt == `LPR_FRAME_BITS;
  assign sel = state_ff.rx[`LPR_SEL_HI:`LPR_SEL_LO];
  assign readback_select = state_ff.rx[`LPR_RRS_BIT];
  assign no_wr = state_ff.rx[`LPR_NOWR_BIT];

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    // pin synchronisers; first stage feeds only the second
    nxt_state.sclk_s1 = link.sclk;
    nxt_state.sclk_s2 = state_ff.sclk_s1;
    nxt_state.sclk_d = state_ff.sclk_s2;
    nxt_state.csn_s1 = link.csn;
    nxt_state.csn_s2 = state_ff.csn_s1;
    nxt_state.csn_d = state_ff.csn_s2;
    nxt_state.mosi_s1 = link.mosi;
    nxt_state.mosi_s2 = state_ff.mosi_s1;

    // bit engine
    if (csn_fall) begin
      nxt_state.cnt = 5'h00;
      nxt_state.miso = state_ff.tx[15];
    end else if (in_frame && sclk_rise) begin
      nxt_state.rx = {state_ff.rx[14:0], state_ff.mosi_s2};
      // saturate past sixteen so an overlong frame never looks full
      if (state_ff.cnt != 5'h1F) begin
        nxt_state.cnt = state_ff.cnt + 5'h01;
      end
    end else if (in_frame && sclk_fall) begin
      nxt_state.miso = state_ff.tx[14];
      nxt_state.tx = {state_ff.tx[14:0], 1'b0};
    end

    // frame end: decode and write
    if (csn_rise) begin
      nxt_state.miso = 1'b0;
      if (full_frame) begin
        if (sel == `LPR_SEL_CFG) begin
          if (!no_wr) begin
            // reserved bits 11..5 and 1 are dropped
            nxt_state.act_en = state_ff.rx[`LPR_CFG_ACT_BIT];
            nxt_state.edge_sel = state_ff.rx[`LPR_CFG_EDGE_BIT];
            nxt_state.drv_sel = state_ff.rx[`LPR_CFG_DRV_BIT];
            nxt_state.tx_dis = state_ff.rx[`LPR_CFG_TXD_BIT];
          end
        end else if (sel == `LPR_SEL_STUP) begin
          if (!no_wr) begin
            // reserved bits 11,10,8,7,2..0 are dropped
            nxt_state.sdm = state_ff.rx[`LPR_SU_SDM_BIT];
            nxt_state.wdp = state_ff.rx[`LPR_SU_WDP_HI:`LPR_SU_WDP_LO];
            nxt_state.thr = state_ff.rx[`LPR_SU_THR_HI:`LPR_SU_THR_LO];
          end
        end
      end
    end

    // readback word for the next frame, built from updated contents
    if (csn_rise) begin
      nxt_state.tx = 16'h0000;
      if (full_frame && sel == `LPR_SEL_CFG) begin
        if (readback_select) begin
          nxt_state.tx = {2'h3, 2'h2, i_gp1_feedback};
        end else begin
          nxt_state.tx = {2'h3, 2'h0, 7'h00, nxt_state.act_en,
                          nxt_state.edge_sel, nxt_state.drv_sel, 1'b0,
                          nxt_state.tx_dis};
        end
      end else if (full_frame && sel == `LPR_SEL_STUP) begin
        if (readback_select) begin
          nxt_state.tx = {2'h1, 2'h2, 2'h0, nxt_state.sdm, 2'h0,
                          nxt_state.wdp, nxt_state.thr, 3'h0};
        end else begin
          nxt_state.tx = {2'h1, 2'h0, i_int_en_feedback};
        end
      end
    end

    // interface failure latch; set wins over every clear
    if (i_traffic_ok) begin
      nxt_state.fail = 1'b0;
    end
    if (csn_rise && full_frame && sel == `LPR_SEL_CFG && !no_wr &&
        state_ff.rx[`LPR_CFG_TXD_BIT]) begin
      nxt_state.fail = 1'b0;
    end
    if (i_if_fail) begin
      nxt_state.fail = 1'b1;
    end

    // wake status
    if (i_wake_status_clr) begin
      nxt_state.edge_wake_status = 1'b0;
    end
    if (i_wake_enable) begin
      if (i_wake_edge) begin
        nxt_state.edge_wake_status = 1'b1;
      end
      nxt_state.wake_level_status = i_wake_level;
    end

    // registered decoded outputs
    nxt_state.bus_active = nxt_state.act_en && i_mode_active;
    nxt_state.tx_en = !nxt_state.tx_dis && !nxt_state.fail;
    nxt_state.wd_x2 = lpr_pkg::lpr_wd_x2(nxt_state.wdp);
    nxt_state.thr_pct = lpr_pkg::lpr_thr_pct(nxt_state.thr);
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_ff <= '0;
      state_ff.sclk_s1 <= 1'b0;
      state_ff.csn_s1 <= 1'b1;
      state_ff.csn_s2 <= 1'b1;
      state_ff.csn_d <= 1'b1;
      state_ff.act_en <= 1'(`LPR_RST_CFG >> `LPR_CFG_ACT_BIT);
      state_ff.sdm <= `LPR_RST_SDM;
      state_ff.wdp <= `LPR_RST_WDP;
      state_ff.thr <= `LPR_RST_THR;
      state_ff.tx_en <= 1'b1;
      state_ff.wd_x2 <= `LPR_WDX2_00;
      state_ff.thr_pct <= `LPR_THR_PCT_HI;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign link.miso = state_ff.miso;
  assign o_bus_active = state_ff.bus_active;
  assign o_edge_rate_sel = state_ff.edge_sel;
  assign o_drive_strength_sel = state_ff.drv_sel;
  assign o_transmitter_disable = state_ff.tx_dis;
  assign o_tx_enable = state_ff.tx_en;
  assign o_sw_dev_mode_init = state_ff.sdm;
  assign o_watchdog_prescale = state_ff.wdp;
  assign o_supply_reset_threshold = state_ff.thr;
  assign o_wd_scale_x2 = state_ff.wd_x2;
  assign o_reset_thresh_pct = state_ff.thr_pct;
  assign o_edge_wake_status = state_ff.edge_wake_status;
  assign o_wake_level_status = state_ff.wake_level_status;
endmodule

//--- rtl/lpr_host.sv
/*
  Controller end: APB slave with a command, status and receive
  register; each command write made while idle sends one 16-bit frame, msb first.
  Assumes APB master on i_clk and the device end on the link.
*/
`include "lpr_regs.svh"
module lpr_host #(
  parameter logic [7:0] HALF_CYC = `LPR_HALF_CYC
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  lpr_if.host link
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  lpr_pkg::lpr_host_s state_ff;
  lpr_pkg::lpr_host_s nxt_state;

  logic busy;
  logic acc;
  logic half_end;

  assign busy = state_ff.st != lpr_pkg::LPR_IDLE;
  assign acc = i_psel && i_penable;
  assign half_end = state_ff.cnt == HALF_CYC - 8'h01;

  // reserved positions forced to zero before a frame leaves
  function automatic logic [15:0] lpr_frame_clean(input logic [15:0] f);
    lpr_frame_clean = f;
    if (f[`LPR_SEL_HI:`LPR_SEL_LO] == `LPR_SEL_CFG) begin
      lpr_frame_clean[11:5] = 7'h00;
      lpr_frame_clean[1] = 1'b0;
    end else if (f[`LPR_SEL_HI:`LPR_SEL_LO] == `LPR_SEL_STUP) begin
      lpr_frame_clean[11:10] = 2'h0;
      lpr_frame_clean[8:7] = 2'h0;
      lpr_frame_clean[2:0] = 3'h0;
    end
  endfunction

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    nxt_state.miso_s1 = link.miso;
    nxt_state.miso_s2 = state_ff.miso_s1;

    // apb: one wait state, answer registered
    if (acc && !state_ff.pready) begin
      nxt_state.pready = 1'b1;
      nxt_state.pslverr = 1'b0;
      nxt_state.wr_ok = 1'b0;
      nxt_state.prdata = 32'h0000_0000;
      if (i_paddr == `LPR_HOST_CMD) begin
        nxt_state.prdata = {16'h0000, state_ff.txw};
        nxt_state.pslverr = i_pwrite && busy;
        nxt_state.wr_ok = i_pwrite && !busy;
      end else if (i_paddr == `LPR_HOST_STAT) begin
        nxt_state.prdata = {30'h0000_0000, state_ff.done, busy};
        nxt_state.pslverr = i_pwrite;
      end else if (i_paddr == `LPR_HOST_RXD) begin
        nxt_state.prdata = {16'h0000, state_ff.rxw};
        nxt_state.pslverr = i_pwrite;
      end else begin
        nxt_state.pslverr = 1'b1;
      end
    end else if (acc && state_ff.pready) begin
      nxt_state.pready = 1'b0;
      nxt_state.pslverr = 1'b0;
      nxt_state.wr_ok = 1'b0;
      if (state_ff.wr_ok) begin
        nxt_state.txw = lpr_frame_clean(i_pwdata[15:0]);
        nxt_state.sh = {nxt_state.txw[14:0], 1'b0};
        nxt_state.mosi = nxt_state.txw[15];
        nxt_state.csn = 1'b0;
        nxt_state.cnt = 8'h00;
        nxt_state.bits = 4'h0;
        nxt_state.done = 1'b0;
        nxt_state.st = lpr_pkg::LPR_LEAD;
      end
    end

    // frame engine
    case (state_ff.st)
      lpr_pkg::LPR_LEAD: begin
        nxt_state.cnt = state_ff.cnt + 8'h01;
        if (half_end) begin
          nxt_state.cnt = 8'h00;
          nxt_state.sclk = 1'b1;
          nxt_state.st = lpr_pkg::LPR_SHIFT;
        end
      end
      lpr_pkg::LPR_SHIFT: begin
        nxt_state.cnt = state_ff.cnt + 8'h01;
        if (half_end) begin
          nxt_state.cnt = 8'h00;
          nxt_state.sclk = !state_ff.sclk;
          if (state_ff.sclk) begin
            nxt_state.rxw = {state_ff.rxw[14:0], state_ff.miso_s2};
            nxt_state.bits = state_ff.bits + 4'h1;
            if (state_ff.bits == 4'hF) begin
              nxt_state.st = lpr_pkg::LPR_TAIL;
            end else begin
              nxt_state.mosi = state_ff.sh[15];
              nxt_state.sh = {state_ff.sh[14:0], 1'b0};
            end
          end
        end
      end
      lpr_pkg::LPR_TAIL: begin
        nxt_state.cnt = state_ff.cnt + 8'h01;
        if (half_end) begin
          nxt_state.csn = 1'b1;
        end
        if (state_ff.cnt == {HALF_CYC[6:0], 1'b0} - 8'h01) begin
          nxt_state.cnt = 8'h00;
          nxt_state.mosi = 1'b0;
          nxt_state.done = 1'b1;
          nxt_state.st = lpr_pkg::LPR_IDLE;
        end
      end
      default: begin
      end
    endcase
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_ff <= '0;
      state_ff.st <= lpr_pkg::LPR_IDLE;
      state_ff.csn <= 1'b1;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign o_prdata = state_ff.prdata;
  assign o_pready = state_ff.pready;
  assign o_pslverr = state_ff.pslverr;
  assign link.sclk = state_ff.sclk;
  assign link.csn = state_ff.csn;
  assign link.mosi = state_ff.mosi;
endmodule

//--- verif/lpr_link_asserts.sv
/*
  Checker for the serial link wires between host and device ends.
  Assumes the bench instantiates it beside the link interface.
*/
`include "lpr_regs.svh"
module lpr_link_asserts #(
  parameter logic [7:0] HALF_CYC = `LPR_HALF_CYC
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic sclk,
  input wire logic csn,
  input wire logic mosi,
  input wire logic miso
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  // ----------------------------------------------------------
  // helpers: rises per frame, length of sclk high
  // ----------------------------------------------------------
  logic sclk_q_ff;
  logic [4:0] rise_cnt_ff;
  logic [7:0] hi_run_ff;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sclk_q_ff <= 1'b0;
      rise_cnt_ff <= 5'h00;
      hi_run_ff <= 8'h00;
    end else begin
      sclk_q_ff <= sclk;
      hi_run_ff <= sclk ? hi_run_ff + 8'h01 : 8'h00;
      if (csn) begin
        rise_cnt_ff <= 5'h00;
      end else if (sclk && !sclk_q_ff) begin
        rise_cnt_ff <= rise_cnt_ff + 5'h01;
      end
    end
  end
  // ----------------------------------------------------------
  // assertions
  // ----------------------------------------------------------
  a_idle_sclk_low: assert property (csn |-> !sclk)
    else $error("sclk high outside a frame");
  a_lead_gap: assert property ($fell(csn) |-> !sclk [*4])
    else $error("sclk rose too soon after frame start");
  a_high_len: assert property ($fell(sclk) |-> hi_run_ff == HALF_CYC)
    else $error("sclk high phase has wrong length");
  a_low_len: assert property (($fell(sclk) && rise_cnt_ff < 5'h10) |-> !sclk [*4] ##1 sclk)
    else $error("sclk low phase has wrong length");
  a_bit_count: assert property ($rose(csn) |-> rise_cnt_ff == 5'h10)
    else $error("frame closed without sixteen clocks");
  a_tail_wait: assert property (($fell(sclk) && rise_cnt_ff == 5'h10) |-> !csn [*4] ##1 csn)
    else $error("frame close not four cycles after last fall");
  a_gap_min: assert property ($rose(csn) |-> csn [*4])
    else $error("frame gap too short");
  a_mosi_hold: assert property ((!csn && sclk) |-> $stable(mosi))
    else $error("mosi moved while sclk high");
  a_mosi_edge: assert property ((!csn && !$past(csn) && $changed(mosi)) |-> $fell(sclk))
    else $error("mosi moved away from a falling edge");
  a_miso_hold: assert property ((!csn && sclk && $past(sclk)) |-> $stable(miso))
    else $error("miso moved while sclk high");
  c_full_frame: cover property ($rose(csn) && rise_cnt_ff == 5'h10);
  c_miso_one: cover property (!csn && $fell(sclk) && miso);
  c_two_frames: cover property ($rose(csn) ##[4:400] $fell(csn));
endmodule

//--- verif/tb_top.sv
/*
  Self-checking bench: host and device ends joined by the link.
  Assumes both ends, the interface and the checker are compiled.
*/
`include "lpr_regs.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------
  // signals and instances
  // ----------------------------------------------------------
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, e;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic mode = 1'b1, fail = 1'b0, tok = 1'b0;
  logic wen = 1'b0, wedge = 1'b0, wlvl = 1'b0, wclr = 1'b0;
  logic [11:0] gp1 = 12'hA5C, inten = 12'h3C1;
  logic bus_act, edge_sel, drv_sel, tx_dis, tx_en, sdm, edge_wake_status, wake_level_status;
  logic [1:0] wdp, thr;
  logic [2:0] wdx2;
  logic [6:0] pct;
  logic [2:0] wx [4] = '{3'h2, 3'h3, 3'h5, 3'h7};
  logic [6:0] pc [4] = '{7'h5A, 7'h50, 7'h46, 7'h5A};
  int bad_count = 0;
  int samples_checked = 0;
  always #20 clk = ~clk;
  lpr_if link ();
  lpr_host u_lpr_host (.i_clk(clk), .i_rst_n(rst_n), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .link(link.host));
  lpr_dev u_lpr_dev (.i_clk(clk), .i_rst_n(rst_n), .link(link.dev), .i_mode_active(mode),
    .i_if_fail(fail), .i_traffic_ok(tok), .i_gp1_feedback(gp1), .i_int_en_feedback(inten),
    .i_wake_enable(wen), .i_wake_edge(wedge), .i_wake_level(wlvl),
    .i_wake_status_clr(wclr), .o_bus_active(bus_act), .o_edge_rate_sel(edge_sel),
    .o_drive_strength_sel(drv_sel), .o_transmitter_disable(tx_dis), .o_tx_enable(tx_en),
    .o_sw_dev_mode_init(sdm), .o_watchdog_prescale(wdp), .o_supply_reset_threshold(thr),
    .o_wd_scale_x2(wdx2), .o_reset_thresh_pct(pct), .o_edge_wake_status(edge_wake_status),
    .o_wake_level_status(wake_level_status));
  lpr_link_asserts u_lpr_link_asserts (.i_clk(clk), .i_rst_n(rst_n), .sclk(link.sclk),
    .csn(link.csn), .mosi(link.mosi), .miso(link.miso));
  // ----------------------------------------------------------
  // tasks
  // ----------------------------------------------------------
  function automatic logic [31:0] cfgv();
    return {27'h0, bus_act, edge_sel, drv_sel, tx_dis, tx_en};
  endfunction
  function automatic logic [31:0] suv();
    return {17'h0, sdm, wdp, thr, wdx2, pct};
  endfunction
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 64);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      chk("apb answer", 32'h0, 32'h1);
      conclude();
    end
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    do begin
      apb(1'b0, `LPR_HOST_STAT, 32'h0);
      n++;
    end while (q[0] !== 1'b0 && n < 100);
    if (q[0] !== 1'b0) begin
      chk("frame end", 32'h0, 32'h1);
      conclude();
    end
  endtask
  // sends one frame, then checks the word returned by the previous one
  task automatic send(input logic [15:0] f, input logic [15:0] rb);
    apb(1'b1, `LPR_HOST_CMD, {16'h0, f});
    wait_idle();
    chk("stat done", q, 32'h2);
    apb(1'b0, `LPR_HOST_RXD, 32'h0);
    chk("readback", q, {16'h0, rb});
  endtask
  // ----------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------
  initial begin
    logic [15:0] f, prev;
    logic [1:0] c;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    chk("cfg reset", cfgv(), 32'h01);
    chk("su reset", suv(), {17'h0, 1'b0, 2'h0, 2'h0, 3'h2, 7'h5A});
    $display("test reset done");
    send(16'hCFFE, 16'h0000);
    chk("cfg write", cfgv(), 32'h1D);
    apb(1'b0, `LPR_HOST_CMD, 32'h0);
    chk("cmd clean", q, 32'hC01C);
    send(16'hD001, 16'hC01C);
    chk("cfg ro", cfgv(), 32'h1D);
    send(16'hF000, 16'hC01C);
    prev = 16'hEA5C;
    for (int i = 0; i < 4; i++) begin
      c = i[1:0];
      f = {2'b01, 1'b1, 1'b0, 2'b00, c[0], 2'b00, c, c, 3'b000};
      send(f, prev);
      chk("su write", suv(), {17'h0, c[0], c, c, wx[i], pc[i]});
      prev = f;
    end
    send(16'h5000, prev);
    send(16'h0FFF, 16'h43C1);
    send(16'hD000, 16'h0000);
    chk("su kept", suv(), {17'h0, 1'b1, 2'h3, 2'h3, 3'h7, 7'h5A});
    chk("cfg kept", cfgv(), 32'h1D);
    $display("test frames done");
    send(16'hC001, 16'hC01C);
    chk("tx off", cfgv(), 32'h02);
    send(16'hC010, 16'hC001);
    chk("tx on", cfgv(), 32'h11);
    @(posedge clk) fail <= 1'b1;
    @(posedge clk) fail <= 1'b0;
    repeat (3) @(posedge clk);
    chk("if fail", cfgv(), 32'h10);
    @(posedge clk) tok <= 1'b1;
    @(posedge clk) tok <= 1'b0;
    repeat (3) @(posedge clk);
    chk("auto recover", cfgv(), 32'h11);
    @(posedge clk) fail <= 1'b1;
    @(posedge clk) fail <= 1'b0;
    send(16'hC011, 16'hC010);
    chk("manual set", cfgv(), 32'h12);
    send(16'hC010, 16'hC011);
    chk("manual clear", cfgv(), 32'h11);
    @(posedge clk) mode <= 1'b0;
    repeat (3) @(posedge clk);
    chk("mode gate", cfgv(), 32'h01);
    mode <= 1'b1;
    $display("test transmitter done");
    @(posedge clk) wedge <= 1'b1;
    wlvl <= 1'b1;
    @(posedge clk) wedge <= 1'b0;
    repeat (3) @(posedge clk);
    chk("wake off", {30'h0, edge_wake_status, wake_level_status}, 32'h0);
    @(posedge clk) wen <= 1'b1;
    wedge <= 1'b1;
    @(posedge clk) wedge <= 1'b0;
    repeat (3) @(posedge clk);
    chk("wake on", {30'h0, edge_wake_status, wake_level_status}, 32'h3);
    @(posedge clk) wen <= 1'b0;
    wlvl <= 1'b0;
    repeat (3) @(posedge clk);
    chk("wake held", {30'h0, edge_wake_status, wake_level_status}, 32'h3);
    @(posedge clk) wclr <= 1'b1;
    @(posedge clk) wclr <= 1'b0;
    repeat (3) @(posedge clk);
    chk("wake clear", {30'h0, edge_wake_status, wake_level_status}, 32'h1);
    $display("test wake done");
    apb(1'b0, 8'h0C, 32'h0);
    chk("unmapped err", {31'h0, e}, 32'h1);
    chk("unmapped data", q, 32'h0);
    apb(1'b1, `LPR_HOST_STAT, 32'h1);
    chk("stat write", {31'h0, e}, 32'h1);
    apb(1'b1, `LPR_HOST_CMD, 32'hC010);
    apb(1'b1, `LPR_HOST_CMD, 32'hC001);
    chk("busy write", {31'h0, e}, 32'h1);
    wait_idle();
    chk("busy no effect", cfgv(), 32'h11);
    $display("test host bus done");
    conclude();
  end
endmodule
